//--- rtl/flash_config_master.sv
// Parallel NOR flash configuration master: fetch loop, pins, fallback.
// Assumes program_n is tied into resetn by the chip reset tree.
`timescale 1ns/10ps
module flash_config_master (
    input  wire logic        clock,
    input  wire logic        resetn,
    input  wire logic [2:0]  mode_pins,
    input  wire logic        status_in,
    output logic             status_out,
    output logic             status_oe,
    input  wire logic        done_in,
    input  wire logic        crc_error,
    input  wire logic        upset_detection,
    input  wire logic        readback_crc_error,
    input  wire logic        pullup_select,
    input  wire logic        rev_set_valid,
    input  wire logic [1:0]  rev_set_value,
    input  wire logic        chain_select,
    input  wire logic [15:0] flash_data,
    output logic             config_clock,
    output logic [25:0]      flash_addr,
    output logic             flash_addr_oe,
    output logic             flash_select_n,
    output logic             flash_select_oe,
    output logic             flash_read_enable_n,
    output logic             flash_read_enable_oe,
    output logic             flash_write_enable_n,
    output logic             flash_write_enable_oe,
    output logic [1:0]       revision_select,
    output logic             revision_select_oe,
    output logic             revision_pullup,
    output logic             chain_select_out_n,
    output logic [15:0]      config_word,
    output logic             config_word_valid,
    output logic             bus_is_wide,
    output logic             config_error,
    output logic             global_tristate,
    output logic             flash_mode_descending
);
    flash_loader_pkg::loader_state_e state;
    logic        status_level;
    logic        done_level;
    logic [15:0] data_level;
    logic [7:0]  div_count;
    logic        config_clock_rise;
    logic        config_clock_fall;
    logic [3:0]  hold_count;
    logic [1:0]  detect_count;
    logic        last_addr;

    // ===========================================================
    // Pin synchronisers
    pin_sync #(.WIDTH(1), .INIT(16'h0000)) u_status_sync (
        .clock  (clock),
        .resetn (resetn),
        .pin    (status_in),
        .level  (status_level)
    );

    pin_sync #(.WIDTH(1), .INIT(16'h0000)) u_done_sync (
        .clock  (clock),
        .resetn (resetn),
        .pin    (done_in),
        .level  (done_level)
    );

    // Data is quasi-static while sampled, three stages keep it aligned
    pin_sync #(.WIDTH(16), .INIT(16'h0000)) u_data_sync (
        .clock  (clock),
        .resetn (resetn),
        .pin    (flash_data),
        .level  (data_level)
    );

    // ===========================================================
    // Config clock divider
    always_ff @(posedge clock)
    begin
        if (!resetn)
        begin
            div_count    <= 8'h00;
            config_clock <= 1'b0;
        end
        else
        begin
            if (div_count == 8'(flash_loader_pkg::CONFIG_CLOCK_DIV - 1))
                div_count <= 8'h00;
            else
                div_count <= div_count + 8'h01;
            config_clock <= (div_count < 8'(flash_loader_pkg::CONFIG_CLOCK_HALF));
        end
    end

    assign config_clock_rise = (div_count == 8'h00);
    assign config_clock_fall = (div_count == 8'(flash_loader_pkg::CONFIG_CLOCK_HALF));

    assign last_addr = flash_mode_descending
        ? (flash_addr == flash_loader_pkg::ADDR_BOTTOM)
        : (flash_addr == flash_loader_pkg::ADDR_TOP);

    // ===========================================================
    // Fetch sequencer
    always_ff @(posedge clock)
    begin
        if (!resetn)
        begin
            state                 <= flash_loader_pkg::ST_WAIT_INIT;
            flash_addr            <= flash_loader_pkg::ADDR_BOTTOM;
            flash_mode_descending <= 1'b0;
            hold_count            <= 4'h0;
            config_error          <= 1'b0;
            global_tristate       <= 1'b1;
        end
        else
        begin
            unique case (state)
                flash_loader_pkg::ST_WAIT_INIT:
                    if (status_level)
                        state <= flash_loader_pkg::ST_SAMPLE;
                flash_loader_pkg::ST_SAMPLE:
                begin
                    if (mode_pins == flash_loader_pkg::MODE_DESCENDING)
                    begin
                        flash_mode_descending <= 1'b1;
                        flash_addr <= flash_loader_pkg::ADDR_TOP;
                        state <= flash_loader_pkg::ST_FIRST;
                    end
                    else if (mode_pins == flash_loader_pkg::MODE_ASCENDING)
                    begin
                        flash_addr <= flash_loader_pkg::ADDR_BOTTOM;
                        state <= flash_loader_pkg::ST_FIRST;
                    end
                    else
                        state <= flash_loader_pkg::ST_IDLE;
                    hold_count <= 4'h0;
                end
                flash_loader_pkg::ST_FIRST:
                    if (config_clock_fall)
                    begin
                        if (hold_count == 4'(flash_loader_pkg::FIRST_HOLD_CYCLES))
                            state <= flash_loader_pkg::ST_FETCH;
                        else
                            hold_count <= hold_count + 4'h1;
                    end
                flash_loader_pkg::ST_FETCH:
                    if (done_level)
                        state <= flash_loader_pkg::ST_RELEASE;
                    else if (config_clock_rise)
                    begin
                        if (last_addr)
                        begin
                            config_error <= 1'b1;
                            state <= flash_loader_pkg::ST_IDLE;
                        end
                        else if (flash_mode_descending)
                            flash_addr <= flash_addr - 26'h0000001;
                        else
                            flash_addr <= flash_addr + 26'h0000001;
                    end
                flash_loader_pkg::ST_RELEASE:
                    if (config_clock_rise)
                    begin
                        global_tristate <= 1'b0;
                        state <= flash_loader_pkg::ST_USER;
                    end
                flash_loader_pkg::ST_USER:
                    state <= flash_loader_pkg::ST_USER;
                flash_loader_pkg::ST_IDLE:
                    state <= flash_loader_pkg::ST_IDLE;
                default:
                    state <= flash_loader_pkg::ST_IDLE;
            endcase
        end
    end

    // ===========================================================
    // Flash control pins
    always_ff @(posedge clock)
    begin
        if (!resetn)
        begin
            flash_select_n        <= 1'b1;
            flash_select_oe       <= 1'b0;
            flash_read_enable_n   <= 1'b1;
            flash_read_enable_oe  <= 1'b0;
            flash_write_enable_n  <= 1'b1;
            flash_write_enable_oe <= 1'b0;
            flash_addr_oe         <= 1'b0;
        end
        else
        begin
            flash_select_n        <= !(state == flash_loader_pkg::ST_FIRST
                                    || state == flash_loader_pkg::ST_FETCH);
            flash_select_oe       <= (state == flash_loader_pkg::ST_FIRST
                                    || state == flash_loader_pkg::ST_FETCH);
            flash_read_enable_n   <= !(state == flash_loader_pkg::ST_FIRST
                                    || state == flash_loader_pkg::ST_FETCH);
            flash_read_enable_oe  <= (state == flash_loader_pkg::ST_FIRST
                                    || state == flash_loader_pkg::ST_FETCH);
            flash_write_enable_n  <= 1'b1;
            flash_write_enable_oe <= (state == flash_loader_pkg::ST_FIRST
                                    || state == flash_loader_pkg::ST_FETCH);
            flash_addr_oe         <= (state == flash_loader_pkg::ST_FIRST
                                    || state == flash_loader_pkg::ST_FETCH);
        end
    end

    // ===========================================================
    // Data capture and width detection
    always_ff @(posedge clock)
    begin
        if (!resetn)
        begin
            config_word       <= 16'h0000;
            config_word_valid <= 1'b0;
            bus_is_wide       <= 1'b0;
            detect_count      <= 2'h0;
        end
        else
        begin
            config_word_valid <= 1'b0;
            if (config_clock_rise && state == flash_loader_pkg::ST_FETCH && !done_level)
            begin
                // Wide bus seen when upper lines are not all ones in the first DETECT_WORDS words
                if (detect_count != 2'(flash_loader_pkg::DETECT_WORDS))
                begin
                    detect_count <= detect_count + 2'h1;
                    if (data_level[15:8] != 8'hFF)
                        bus_is_wide <= 1'b1;
                end
                config_word <= (bus_is_wide || (data_level[15:8] != 8'hFF
                    && detect_count != 2'(flash_loader_pkg::DETECT_WORDS)))
                    ? data_level : {8'h00, data_level[7:0]};
                config_word_valid <= 1'b1;
            end
        end
    end

    // ===========================================================
    // Status pin, revision select, chain select
    always_ff @(posedge clock)
    begin
        if (!resetn)
        begin
            status_out         <= 1'b0;
            status_oe          <= 1'b0;
            revision_select    <= 2'h3;
            revision_select_oe <= 1'b0;
            revision_pullup    <= 1'b0;
            chain_select_out_n <= 1'b1;
        end
        else
        begin
            if (state != flash_loader_pkg::ST_WAIT_INIT
                && state != flash_loader_pkg::ST_SAMPLE)
                status_oe <= crc_error
                          || (upset_detection && readback_crc_error);
            else
                status_oe <= 1'b0;
            revision_pullup <= !pullup_select
                            && !revision_select_oe;
            if (config_error)
            begin
                revision_select    <= flash_loader_pkg::REV_FALLBACK;
                revision_select_oe <= 1'b1;
            end
            else if (rev_set_valid)
            begin
                revision_select    <= rev_set_value;
                revision_select_oe <= 1'b1;
            end
            chain_select_out_n <= !(chain_select
                && state == flash_loader_pkg::ST_FETCH);
        end
    end

    // ===========================================================
    // Checks
    AST_WRITE_HIGH: assert property (@(posedge clock) disable iff (!resetn)
        flash_write_enable_oe |-> flash_write_enable_n)
        else $error("write enable low while driven");
    AST_SELECT_DRIVEN: assert property (@(posedge clock) disable iff (!resetn)
        (state == flash_loader_pkg::ST_FETCH) |=> (!flash_select_n && flash_select_oe))
        else $error("select not driven during fetch");
    AST_READ_DRIVEN: assert property (@(posedge clock) disable iff (!resetn)
        (state == flash_loader_pkg::ST_USER) |=> !flash_read_enable_oe)
        else $error("read enable still driven after load");
    AST_STATUS_INPUT: assert property (@(posedge clock) disable iff (!resetn)
        (state == flash_loader_pkg::ST_WAIT_INIT) |=> !status_oe)
        else $error("status driven before mode sampling");
    AST_STOP_ON_DONE: assert property (@(posedge clock) disable iff (!resetn)
        (state == flash_loader_pkg::ST_RELEASE) |=> $stable(flash_addr))
        else $error("address moved after completion");
    AST_ASC_STEP: assert property (@(posedge clock) disable iff (!resetn)
        (state == flash_loader_pkg::ST_FETCH && !done_level && config_clock_rise
         && !last_addr && !flash_mode_descending)
        |=> flash_addr == $past(flash_addr) + 26'h0000001)
        else $error("ascending step wrong");
    AST_DESC_STEP: assert property (@(posedge clock) disable iff (!resetn)
        (state == flash_loader_pkg::ST_FETCH && !done_level && config_clock_rise
         && !last_addr && flash_mode_descending)
        |=> flash_addr == $past(flash_addr) - 26'h0000001)
        else $error("descending step wrong");
    AST_FALLBACK: assert property (@(posedge clock) disable iff (!resetn)
        $rose(config_error) |=> ##[0:1] (revision_select_oe
                                && revision_select == 2'h0))
        else $error("fallback select not driven");
    AST_RELEASE: assert property (@(posedge clock) disable iff (!resetn)
        (state == flash_loader_pkg::ST_RELEASE)
        |-> ##[1:10] !global_tristate)
        else $error("tristate release late");
endmodule : flash_config_master

//--- rtl/flash_loader_pkg.sv
// Constants shared by the parallel flash configuration loader.
// Assumes one 125 MHz clock and a synchronous active-low reset.
package flash_loader_pkg;

    // ==========================================================
    // Widths
    localparam int ADDR_W = 26;
    localparam int DATA_W = 16;
    localparam int SYNC_W = 3;

    // ==========================================================
    // Mode pin codes
    localparam logic [2:0] MODE_ASCENDING  = 3'h2;
    localparam logic [2:0] MODE_DESCENDING = 3'h3;

    // ==========================================================
    // Addresses
    localparam logic [ADDR_W-1:0] ADDR_BOTTOM = 26'h0000000;
    localparam logic [ADDR_W-1:0] ADDR_TOP    = 26'h3FFFFFF;

    // ==========================================================
    // Timing
    localparam int CLK_PERIOD_NS     = 8;
    localparam int CONFIG_CLOCK_PERIOD_NS    = 80;
    localparam int CONFIG_CLOCK_DIV          = CONFIG_CLOCK_PERIOD_NS / CLK_PERIOD_NS;
    localparam int CONFIG_CLOCK_HALF         = CONFIG_CLOCK_DIV / 2;
    localparam int FIRST_HOLD_CYCLES = 4;
    localparam int RELEASE_CYCLES    = 1;
    localparam int DETECT_WORDS      = 2;

    // ==========================================================
    // Fallback values
    localparam logic [1:0] REV_FALLBACK = 2'h0;

    typedef enum logic [2:0] {
        ST_WAIT_INIT = 3'b000,
        ST_SAMPLE    = 3'b001,
        ST_FIRST     = 3'b010,
        ST_FETCH     = 3'b011,
        ST_RELEASE   = 3'b100,
        ST_USER      = 3'b101,
        ST_IDLE      = 3'b110
    } loader_state_e;

endpackage : flash_loader_pkg

//--- rtl/pin_sync.sv
// Three-stage pin synchroniser; change taken when stages two and three agree.
// Assumes the pin is asynchronous to clock.
`timescale 1ns/10ps
module pin_sync #(
    parameter int          WIDTH = 1,
    parameter logic [15:0] INIT  = 16'h0000
) (
    input  wire logic             clock,
    input  wire logic             resetn,
    input  wire logic [WIDTH-1:0] pin,
    output logic      [WIDTH-1:0] level
);
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;

    always_ff @(posedge clock)
    begin
        if (!resetn)
        begin
            meta   <= INIT[WIDTH-1:0];
            stage2 <= INIT[WIDTH-1:0];
            stage3 <= INIT[WIDTH-1:0];
            level  <= INIT[WIDTH-1:0];
        end
        else
        begin
            meta   <= pin;
            stage2 <= meta;
            stage3 <= stage2;
            // Per bit: accept only where stages two and three agree
            level  <= (stage2 & ~(stage2 ^ stage3))
                    | (level & (stage2 ^ stage3));
        end
    end
endmodule : pin_sync

//--- verif/nor_flash_model.sv
// Behavioural parallel NOR flash serving asynchronous reads.
// Assumes the bench ties it to the loader's flash pins.
`timescale 1ns/10ps
module nor_flash_model #(
    parameter int ACCESS_NS = 36
) (
    input  wire logic        wide,
    input  wire logic [25:0] addr,
    input  wire logic        select_n,
    input  wire logic        read_n,
    input  wire logic        driven,
    output logic      [15:0] data
);
    // ==========================================================
    // Image: upper byte tied to lower on a wide bus, all ones on a narrow one, so stale data is caught
    logic [15:0] stored;
    logic [15:0] junk  = 16'hA5C3;
    logic        ready = 1'b0;
    int          stamp = 0;

    assign stored = wide ? {addr[7:0] + 8'h5A, addr[7:0]}
                         : {8'hFF, addr[7:0]};

    // ==========================================================
    // Access restarts on any change; lines churn until it ends
    always @(addr, select_n, read_n, driven)
    begin
        ready = 1'b0;
        stamp = stamp + 1;
        fork
            settle(stamp);
        join_none
    end

    task automatic settle(input int tag);
        #(ACCESS_NS);
        if (tag == stamp && !select_n && !read_n && driven)
            ready = 1'b1;
    endtask : settle

    // Flips between clock rises so a synchroniser never sees it settle
    always #8 junk = ~junk;
    assign data = ready ? stored : junk;
endmodule : nor_flash_model

//--- verif/parallel_flash_config_master_bench.sv
// Bench for the flash configuration loader, scenario per task.
// Assumes a 125 MHz clock and the behavioural flash model.
`timescale 1ns/10ps
module parallel_flash_config_master_bench;
    // ==========================================================
    // Stimulus and observed pins
    logic clock = 0, resetn = 0, status_in = 0, done_in = 0;
    logic crc_error = 0, upset_detection = 0, readback_crc_error = 0;
    logic pullup_select = 0, rev_set_valid = 0, chain_select = 0;
    logic [2:0] mode_pins = 3'h2;
    logic [1:0] rev_set_value = 2'h0;
    logic [15:0] flash_data, config_word;
    logic [25:0] flash_addr;
    logic [1:0] revision_select;
    logic status_out, status_oe, config_clock, flash_addr_oe;
    logic flash_select_n, flash_select_oe, flash_read_enable_n;
    logic flash_read_enable_oe, flash_write_enable_n;
    logic flash_write_enable_oe, revision_select_oe, revision_pullup;
    logic chain_select_out_n, config_word_valid, bus_is_wide;
    logic config_error, global_tristate, flash_mode_descending;
    logic wide = 1, desc = 0;
    logic [7:0] last_lo;
    int fails = 0, checked = 0, words = 0, ticks = 0;

    always #4 clock = ~clock;

    flash_config_master flash_config_master_i (
        .clock (clock), .resetn (resetn), .mode_pins (mode_pins),
        .status_in (status_in), .status_out (status_out),
        .status_oe (status_oe), .done_in (done_in), .crc_error (crc_error),
        .upset_detection (upset_detection),
        .readback_crc_error (readback_crc_error),
        .pullup_select (pullup_select), .rev_set_valid (rev_set_valid),
        .rev_set_value (rev_set_value), .chain_select (chain_select),
        .flash_data (flash_data), .config_clock (config_clock),
        .flash_addr (flash_addr), .flash_addr_oe (flash_addr_oe),
        .flash_select_n (flash_select_n),
        .flash_select_oe (flash_select_oe),
        .flash_read_enable_n (flash_read_enable_n),
        .flash_read_enable_oe (flash_read_enable_oe),
        .flash_write_enable_n (flash_write_enable_n),
        .flash_write_enable_oe (flash_write_enable_oe),
        .revision_select (revision_select),
        .revision_select_oe (revision_select_oe),
        .revision_pullup (revision_pullup),
        .chain_select_out_n (chain_select_out_n),
        .config_word (config_word),
        .config_word_valid (config_word_valid),
        .bus_is_wide (bus_is_wide), .config_error (config_error),
        .global_tristate (global_tristate),
        .flash_mode_descending (flash_mode_descending)
    );

    nor_flash_model nor_flash_model_i (
        .wide     (wide),
        .addr     (flash_addr),
        .select_n (flash_select_n),
        .read_n   (flash_read_enable_n),
        .driven   (flash_select_oe & flash_read_enable_oe),
        .data     (flash_data)
    );

    // ==========================================================
    // Shared helpers
    task automatic check(string what, logic [25:0] exp, logic [25:0] got);
        checked++;
        if (got !== exp)
        begin
            fails++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic cyc(int n);
        repeat (n) @(posedge clock);
    endtask : cyc

    task automatic tick();
        @(posedge clock);
        #1;
    endtask : tick

    task automatic finish_test();
        if (fails == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : finish_test

    // Mode set before release, start held off until status goes high
    task automatic restart(logic [2:0] mode, logic w);
        cyc(1);
        resetn <= 0;
        status_in <= 0;
        done_in <= 0;
        mode_pins <= mode;
        wide <= w;
        desc <= (mode == 3'h3);
        cyc(16);
        resetn <= 1;
        words = 0;
    endtask : restart

    task automatic go();
        int n;
        cyc(1);
        status_in <= 1;
        n = 0;
        do begin tick(); n++; end
        while (flash_select_oe !== 1'b1 && n < 200);
    endtask : go

    // ==========================================================
    // Word monitor: pairing, width and address direction
    always @(posedge clock)
    begin
        ticks++;
        if (ticks == 20000)
        begin
            fails++;
            finish_test();
        end
        if (resetn && config_word_valid === 1'b1)
        begin
            words++;
            if (wide)
                check("wide word", {10'h0, config_word[7:0] + 8'h5A,
                    config_word[7:0]}, {10'h0, config_word});
            else
                check("narrow word", {18'h0, config_word[7:0]},
                    {10'h0, config_word});
            if (words == 1)
                check("first word", {18'h0, desc ? 8'hFF : 8'h00},
                    {18'h0, config_word[7:0]});
            else
                check("word step", {18'h0, last_lo + (desc ? 8'hFF : 8'h01)},
                    {18'h0, config_word[7:0]});
            last_lo = config_word[7:0];
        end
    end

    // ==========================================================
    // Scenarios
    task automatic test_hold_start();
        restart(3'h2, 1);
        cyc(80);
        #1;
        check("select oe held", 26'h0, flash_select_oe);
        check("status oe held", 26'h0, status_oe);
        check("write oe", 26'h0, flash_write_enable_oe);
        check("rev oe", 26'h0, revision_select_oe);
        check("rev pullup", 26'h1, revision_pullup);
        check("tristate", 26'h1, global_tristate);
    endtask : test_hold_start

    task automatic test_ascending();
        int n;
        logic last;
        go();
        check("select", 26'h2, {flash_select_oe, flash_select_n});
        check("read", 26'h2, {flash_read_enable_oe,
            flash_read_enable_n});
        check("write", 26'h3, {flash_write_enable_oe,
            flash_write_enable_n});
        check("first addr", flash_loader_pkg::ADDR_BOTTOM, flash_addr);
        check("addr oe", 26'h1, flash_addr_oe);
        n = 0;
        while (flash_addr === 26'h0 && n < 300) begin tick(); n++; end
        check("first hold", 26'h1, n >= flash_loader_pkg::FIRST_HOLD_CYCLES
            * flash_loader_pkg::CONFIG_CLOCK_DIV);
        check("second addr", 26'h0000001, flash_addr);
        n = 0;
        last = config_clock;
        repeat (10 * flash_loader_pkg::CONFIG_CLOCK_DIV)
        begin
            tick();
            if (config_clock && !last)
                n++;
            last = config_clock;
        end
        check("clock rises", 26'h000000A, n);
        n = 0;
        while (words < 12 && n < 400) begin tick(); n++; end
        check("words seen", 26'h1, words >= 12);
        check("wide", 26'h1, bus_is_wide);
        check("ascending", 26'h0, flash_mode_descending);
    endtask : test_ascending

    task automatic test_done();
        int n, w;
        logic [25:0] a;
        cyc(1);
        done_in <= 1;
        upset_detection <= 1;
        n = 0;
        do begin tick(); n++; end
        while (flash_select_oe !== 1'b0 && n < 60);
        check("select released", 26'h0, flash_select_oe);
        a = flash_addr;
        w = words;
        n = 0;
        do begin tick(); n++; end
        while (global_tristate !== 1'b0 && n < 40);
        check("tristate off", 26'h0, global_tristate);
        cyc(40);
        #1;
        check("addr frozen", a, flash_addr);
        check("no more words", w, words);
        check("oe released", 26'h0, {flash_read_enable_oe,
            flash_write_enable_oe});
        check("no crc", 26'h0, status_oe);
        check("no error", 26'h0, config_error);
        cyc(1);
        readback_crc_error <= 1;
        cyc(2);
        #1;
        check("readback crc", 26'h1, status_oe);
        cyc(1);
        readback_crc_error <= 0;
        upset_detection <= 0;
    endtask : test_done

    task automatic test_crc_user_reset();
        restart(3'h2, 1);
        crc_error <= 1;
        chain_select <= 1;
        go();
        cyc(8);
        rev_set_valid <= 1;
        rev_set_value <= 2'h2;
        cyc(1);
        rev_set_valid <= 0;
        cyc(48);
        #1;
        check("crc low", 26'h1, status_oe);
        check("rev user", 26'h6, {revision_select_oe,
            revision_select});
        check("chain select", 26'h0, chain_select_out_n);
        check("status level", 26'h0, status_out);
        cyc(1);
        resetn <= 0;
        crc_error <= 0;
        chain_select <= 0;
        cyc(2);
        #1;
        check("reset select", 26'h0, flash_select_oe);
        check("reset addr", 26'h0, flash_addr);
        check("reset tristate", 26'h1, global_tristate);
    endtask : test_crc_user_reset

    task automatic test_descending();
        int n;
        restart(3'h3, 0);
        go();
        check("top addr", flash_loader_pkg::ADDR_TOP, flash_addr);
        n = 0;
        while (words < 8 && n < 600) begin tick(); n++; end
        check("words seen", 26'h1, words >= 8);
        check("narrow", 26'h0, bus_is_wide);
        check("descending", 26'h1, flash_mode_descending);
    endtask : test_descending

    task automatic test_bad_mode();
        restart(3'h0, 1);
        cyc(1);
        status_in <= 1;
        cyc(120);
        #1;
        check("bad mode idle", 26'h0, {flash_select_oe,
            flash_addr_oe});
    endtask : test_bad_mode

    initial
    begin
        test_hold_start();
        test_ascending();
        test_done();
        test_crc_user_reset();
        test_descending();
        test_bad_mode();
        finish_test();
    end
endmodule : parallel_flash_config_master_bench
